// file: drive_network_input_decoder.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - run/stop true with value 1..200 runs at 0.5% per step.
// - false gives stop word; true/0 gives run word at 0%; 201..255 runs 100%.
// - a 0xFF state on run/stop or fault-clear is ignored.
// - run/stop reference used only while percent and frequency references are zero.
// - a 16-bit control word input steers the drive control word.
// - fault-clear true sets bit 7, giving the reset word; false gives no reset.
// - percent reference is a signed share of the reference range, 0.005% units.
// - in closed loop the percent reference acts as the setpoint.
// - frequency reference, 0.1 Hz units, is speed in open loop, setpoint closed.
// - three closed-loop setpoint inputs, 0.005% units, signed.
// - three network feedback inputs, same scaling as setpoints.
// - a 64-bit word drives discrete outputs, one means on.
// - bits 0..8 map to outputs and relays; bits 9..63 reserved.
// - first analog output follows its value only with a bus function code.
// - codes 139 and 140 hold the analog level on bus timeout.
// - codes 141 and 142 load the timeout preset on bus timeout.
// - codes 139/141 scale 0-20 mA, codes 140/142 scale 4-20 mA.
// - second analog output acts only with the expansion board fitted.
// - second analog output has its own code and preset, same behaviour.
// - two more analog output values for the analog I/O board.
// - those two values act only with the analog I/O board fitted.
module drive_network_input_decoder
  import drive_nv_pkg::*;
(
  // clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // axi4-lite write address
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [7:0]           awaddr,
  // axi4-lite write data
  input  wire logic                 wvalid,
  output logic                      wready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  // axi4-lite write response
  output logic                      bvalid,
  input  wire logic                 bready,
  output logic [1:0]                bresp,
  // axi4-lite read address
  input  wire logic                 arvalid,
  output logic                      arready,
  input  wire logic [7:0]           araddr,
  // axi4-lite read data
  output logic                      rvalid,
  input  wire logic                 rready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  // network supervision
  input  wire logic                 bus_timeout,
  // drive command
  output logic [15:0]               drive_ctl,
  output logic [15:0]               drive_reference,
  output logic                      reference_hz,
  output logic                      reference_is_setpoint,
  // closed-loop data
  output logic [2:0][15:0]          closed_loop_setpoint_inputs,
  output logic [2:0][15:0]          network_feedback_inputs,
  // discrete and analog outputs
  output logic [63:0]               discrete_output_word,
  output logic [3:0][15:0]          ao_level,
  output logic [3:0]                ao_enable,
  output logic [3:0]                ao_span_4ma
);

  // ==========================================================
  // storage
  logic [7:0]  aw_addr;
  logic        aw_got;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_got;
  logic        do_wr;
  logic [32:0] aw_rd;
  logic [32:0] ar_rd;
  logic [31:0] wr_word;
  logic [7:0]  run_stop_state;
  logic [7:0]  run_stop_value;
  logic [7:0]  fault_clear_state;
  logic [15:0] control_word_input;
  logic [15:0] percent_reference_input;
  logic [15:0] frequency_reference_input;
  logic [15:0] run_ref;
  logic        rs_upd;
  logic        cw_upd;
  logic        fc_upd;
  logic [15:0] ao_value [4];
  logic [3:0]  ao_upd;
  logic [31:0] config_word;
  logic [31:0] preset_word;
  logic [3:0]  timed_out;
  logic [7:0]  ao_func [4];
  logic [3:0]  ao_present;
  logic [15:0] ao_preset [4];
  logic [15:0] next_ao_level [4];

  // register decode shared by write merge and read path; bit 32 is a hit
  function automatic logic [32:0] reg_read(input logic [7:0] a);
    logic [32:0] r;
    r = {1'b1, RST_WORD};
    case (a)
      OFF_RUN_STOP:  r[15:0] = {run_stop_state, run_stop_value};
      OFF_CTRL_WORD: r[15:0] = control_word_input;
      OFF_FAULT_CLR: r[STATE_LSB +: 8] = fault_clear_state;
      OFF_PCT_REF:   r[15:0] = percent_reference_input;
      OFF_HZ_REF:    r[15:0] = frequency_reference_input;
      OFF_DOUT_LO:   r[31:0] = discrete_output_word[31:0];
      OFF_DOUT_HI:   r[31:0] = discrete_output_word[63:32];
      OFF_CONFIG:    r[31:0] = config_word;
      OFF_PRESET:    r[31:0] = preset_word;
      OFF_STATUS: begin
        r[15:0] = drive_ctl;
        r[STAT_TO_LSB +: 4] = timed_out;
        r[STAT_EN_LSB +: 4] = ao_enable;
      end
      default:       r[32] = 1'b0;
    endcase
    for (int i = 0; i < 3; i++) begin
      if (a == OFF_SETPT[i]) r = {1'b1, 16'h0000, closed_loop_setpoint_inputs[i]};
      if (a == OFF_FBK[i]) r = {1'b1, 16'h0000, network_feedback_inputs[i]};
    end
    for (int i = 0; i < 4; i++) begin
      if (a == OFF_AO[i]) r = {1'b1, 16'h0000, ao_value[i]};
    end
    return r;
  endfunction

  always_comb begin
    aw_rd   = reg_read(aw_addr);
    ar_rd   = reg_read(araddr);
    wr_word = merge(aw_rd[31:0], w_data, w_strb);
  end

  // write fires once both halves are held and no response is pending
  assign do_wr = aw_got && w_got && !bvalid;

  // ==========================================================
  // axi write channels: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      aw_got  <= 1'b0;
      aw_addr <= 8'h00;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_got  <= 1'b1;
      aw_addr <= awaddr;
    end else if (do_wr) begin
      aw_got  <= 1'b0;
    end else begin
      awready <= !aw_got && !bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b0;
      w_got  <= 1'b0;
      w_data <= RST_WORD;
      w_strb <= 4'h0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_got  <= 1'b1;
      w_data <= wdata;
      w_strb <= wstrb;
    end else if (do_wr) begin
      w_got  <= 1'b0;
    end else begin
      wready <= !w_got && !bvalid;
    end
  end

  // unmapped writes are dropped and answered with a slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid <= 1'b1;
      bresp  <= aw_rd[32] ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // axi read channel, one outstanding read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= RST_WORD;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= ar_rd[31:0];
      rresp   <= ar_rd[32] ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
    end else begin
      arready <= !rvalid;
    end
  end

  // ==========================================================
  // network input variables, held until rewritten
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_stop_state            <= RST_STATE;
      run_stop_value            <= 8'h00;
      fault_clear_state         <= RST_STATE;
      control_word_input        <= RST_CTL;
      percent_reference_input   <= 16'h0000;
      frequency_reference_input <= 16'h0000;
      discrete_output_word      <= {2{RST_WORD}};
      config_word               <= RST_WORD;
      preset_word               <= RST_WORD;
      rs_upd                    <= 1'b0;
      cw_upd                    <= 1'b0;
      fc_upd                    <= 1'b0;
    end else begin
      rs_upd <= do_wr && (aw_addr == OFF_RUN_STOP);
      cw_upd <= do_wr && (aw_addr == OFF_CTRL_WORD);
      fc_upd <= do_wr && (aw_addr == OFF_FAULT_CLR);
      if (do_wr) begin
        case (aw_addr)
          OFF_RUN_STOP: begin
            run_stop_value <= wr_word[7:0];
            run_stop_state <= wr_word[STATE_LSB +: 8];
          end
          OFF_CTRL_WORD: control_word_input <= wr_word[15:0];
          OFF_FAULT_CLR: fault_clear_state <= wr_word[STATE_LSB +: 8];
          OFF_PCT_REF:   percent_reference_input <= wr_word[15:0];
          OFF_HZ_REF:    frequency_reference_input <= wr_word[15:0];
          // reserved terminals always read and drive zero
          OFF_DOUT_LO:   discrete_output_word[31:0] <= wr_word & DOUT_MASK[31:0];
          OFF_DOUT_HI:   discrete_output_word[63:32] <= wr_word & DOUT_MASK[63:32];
          OFF_CONFIG:    config_word <= wr_word;
          OFF_PRESET:    preset_word <= wr_word;
          default:       ;
        endcase
      end
    end
  end

  // setpoints and feedbacks share one indexed loop, analog values have a second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      closed_loop_setpoint_inputs <= '0;
      network_feedback_inputs     <= '0;
      ao_upd                      <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        ao_value[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (do_wr && aw_addr == OFF_SETPT[i]) begin
          closed_loop_setpoint_inputs[i] <= wr_word[15:0];
        end
        if (do_wr && aw_addr == OFF_FBK[i]) begin
          network_feedback_inputs[i] <= wr_word[15:0];
        end
      end
      for (int i = 0; i < 4; i++) begin
        ao_upd[i] <= do_wr && (aw_addr == OFF_AO[i]);
        if (do_wr && aw_addr == OFF_AO[i]) ao_value[i] <= wr_word[15:0];
      end
    end
  end

  // ==========================================================
  // control word: one update source per cycle, invalid states ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_ctl <= RST_CTL;
    end else if (fc_upd && fault_clear_state == ST_TRUE) begin
      drive_ctl <= CW_RESET;
    end else if (fc_upd && fault_clear_state == ST_FALSE) begin
      drive_ctl[CW_RESET_BIT] <= 1'b0;
    end else if (rs_upd && run_stop_state == ST_FALSE) begin
      drive_ctl <= CW_STOP;
    end else if (rs_upd && run_stop_state == ST_TRUE) begin
      drive_ctl <= CW_RUN;
    end else if (cw_upd) begin
      drive_ctl <= control_word_input;
    end
  end

  // run/stop reference in 0.005% units, 0.5% per value step
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_ref <= 16'h0000;
    end else if (rs_upd && run_stop_state == ST_TRUE) begin
      if (run_stop_value > RUN_VAL_MAX) begin
        run_ref <= REF_FULL;
      end else begin
        run_ref <= 16'(run_stop_value) * REF_STEP;
      end
    end
  end

  // reference selection: explicit references beat the run/stop one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_reference       <= 16'h0000;
      reference_hz          <= 1'b0;
      reference_is_setpoint <= 1'b0;
    end else begin
      reference_is_setpoint <= config_word[CFG_CLOSED_LOOP];
      if (percent_reference_input != 16'h0000) begin
        drive_reference <= percent_reference_input;
        reference_hz    <= 1'b0;
      end else if (frequency_reference_input != 16'h0000) begin
        drive_reference <= frequency_reference_input;
        reference_hz    <= 1'b1;
      end else begin
        drive_reference <= run_ref;
        reference_hz    <= 1'b0;
      end
    end
  end

  // ==========================================================
  // analog outputs; c and d have no function setting of their own
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ao
      if (g == 0) begin : g_a
        assign ao_func[g]    = config_word[CFG_FN_A_LSB +: 8];
        assign ao_present[g] = 1'b1;
        assign ao_preset[g]  = preset_word[15:0];
      end else if (g == 1) begin : g_b
        assign ao_func[g]    = config_word[CFG_FN_B_LSB +: 8];
        assign ao_present[g] = config_word[CFG_GPIO_BRD];
        assign ao_preset[g]  = preset_word[PRESET_B_LSB +: 16];
      end else begin : g_cd
        assign ao_func[g]    = FN_BUS_0_20;
        assign ao_present[g] = config_word[CFG_AIO_BRD];
        assign ao_preset[g]  = 16'h0000;
      end
      // absent board or non-bus function parks the level at zero
      assign next_ao_level[g] = !(ao_present[g] && is_bus(ao_func[g])) ? 16'h0000 :
                                timed_out[g] ? ao_preset[g] : ao_value[g];
    end
  endgenerate

  // a timeout in the cycle after a value write, while ao_upd is set, wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timed_out   <= 4'h0;
      ao_level    <= '0;
      ao_enable   <= 4'h0;
      ao_span_4ma <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (bus_timeout && has_preset(ao_func[i])) begin
          timed_out[i] <= 1'b1;
        end else if (ao_upd[i] || !has_preset(ao_func[i])) begin
          timed_out[i] <= 1'b0;
        end
        ao_level[i]    <= next_ao_level[i];
        ao_enable[i]   <= ao_present[i] && is_bus(ao_func[i]);
        ao_span_4ma[i] <= is_4ma(ao_func[i]);
      end
    end
  end

  // ==========================================================
  // checks
  AST_STOP: assert property (@(posedge aclk) disable iff (!aresetn)
    rs_upd && run_stop_state == ST_FALSE |=> drive_ctl == CW_STOP)
    else $error("stop word not issued");
  AST_RUN_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    rs_upd && run_stop_state == ST_TRUE && run_stop_value == 8'h00
    |=> drive_ctl == CW_RUN && run_ref == 16'h0000)
    else $error("run at zero wrong");
  AST_RUN_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
    rs_upd && run_stop_state == ST_TRUE && run_stop_value <= RUN_VAL_MAX
    |=> run_ref == 16'($past(run_stop_value)) * REF_STEP)
    else $error("run reference step wrong");
  AST_RUN_FULL: assert property (@(posedge aclk) disable iff (!aresetn)
    rs_upd && run_stop_state == ST_TRUE && run_stop_value > RUN_VAL_MAX
    |=> run_ref == REF_FULL)
    else $error("full run reference wrong");
  AST_INVALID: assert property (@(posedge aclk) disable iff (!aresetn)
    (rs_upd && run_stop_state == ST_INVALID) ||
    (fc_upd && fault_clear_state == ST_INVALID)
    |=> $stable(drive_ctl) && $stable(run_ref))
    else $error("invalid state acted on");
  AST_FAULT: assert property (@(posedge aclk) disable iff (!aresetn)
    fc_upd && fault_clear_state == ST_TRUE |=> drive_ctl == CW_RESET)
    else $error("reset word not issued");
  AST_REF_SEL: assert property (@(posedge aclk) disable iff (!aresetn)
    percent_reference_input == 16'h0000 && frequency_reference_input == 16'h0000
    |=> drive_reference == $past(run_ref) && !reference_hz)
    else $error("run reference not selected");
  AST_AO_PRESET: assert property (@(posedge aclk) disable iff (!aresetn)
    bus_timeout && has_preset(ao_func[0]) |=> timed_out[0]
    ##1 ao_level[0] == $past(ao_preset[0]))
    else $error("preset not loaded on timeout");
  AST_AO_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    ao_enable[0] && !has_preset(ao_func[0]) && $stable(ao_value[0])
    && $stable(ao_func[0]) |=> $stable(ao_level[0]))
    else $error("held level moved");
  AST_AO_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
    !config_word[CFG_GPIO_BRD] |=> !ao_enable[1] && ao_level[1] == 16'h0000)
    else $error("output b active without board");
  localparam int DOUT_USED_TOP = 9;
  AST_DOUT: assert property (@(posedge aclk) disable iff (!aresetn)
    discrete_output_word[63:DOUT_USED_TOP] == '0)
    else $error("reserved output bits set");

endmodule
`default_nettype wire

// file: drive_nv_pkg.sv
`default_nettype none
package drive_nv_pkg;
  // ==========================================================
  // register map, byte addresses
  localparam logic [7:0] OFF_RUN_STOP  = 8'h00;
  localparam logic [7:0] OFF_CTRL_WORD = 8'h04;
  localparam logic [7:0] OFF_FAULT_CLR = 8'h08;
  localparam logic [7:0] OFF_PCT_REF   = 8'h0C;
  localparam logic [7:0] OFF_HZ_REF    = 8'h10;
  localparam logic [7:0] OFF_SETPT [3] = '{8'h14, 8'h18, 8'h1C};
  localparam logic [7:0] OFF_FBK [3]   = '{8'h20, 8'h24, 8'h28};
  localparam logic [7:0] OFF_DOUT_LO   = 8'h2C;
  localparam logic [7:0] OFF_DOUT_HI   = 8'h30;
  localparam logic [7:0] OFF_AO [4]    = '{8'h34, 8'h38, 8'h3C, 8'h40};
  localparam logic [7:0] OFF_CONFIG    = 8'h44;
  localparam logic [7:0] OFF_PRESET    = 8'h48;
  localparam logic [7:0] OFF_STATUS    = 8'h4C;
  // ==========================================================
  // field positions
  localparam int STATE_LSB       = 8;
  localparam int CFG_FN_A_LSB    = 0;
  localparam int CFG_FN_B_LSB    = 8;
  localparam int CFG_CLOSED_LOOP = 16;
  localparam int CFG_GPIO_BRD    = 17;
  localparam int CFG_AIO_BRD     = 18;
  localparam int PRESET_B_LSB    = 16;
  localparam int STAT_TO_LSB     = 16;
  localparam int STAT_EN_LSB     = 20;
  localparam logic [63:0] DOUT_MASK = 64'h0000_0000_0000_01FF;
  // ==========================================================
  // switch states, control words, reference scaling
  localparam logic [7:0]  ST_FALSE    = 8'h00;
  localparam logic [7:0]  ST_TRUE     = 8'h01;
  localparam logic [7:0]  ST_INVALID  = 8'hFF;
  localparam logic [15:0] CW_STOP     = 16'h043C;
  localparam logic [15:0] CW_RUN      = 16'h047C;
  localparam logic [15:0] CW_RESET    = 16'h04BC;
  localparam int          CW_RESET_BIT = 7;
  localparam logic [7:0]  RUN_VAL_MAX = 8'hC8;
  localparam logic [15:0] REF_STEP    = 16'h0064;
  localparam logic [15:0] REF_FULL    = 16'h4E20;
  // ==========================================================
  // analog output function codes
  localparam logic [7:0] FN_BUS_0_20    = 8'h8B;
  localparam logic [7:0] FN_BUS_4_20    = 8'h8C;
  localparam logic [7:0] FN_BUS_0_20_TO = 8'h8D;
  localparam logic [7:0] FN_BUS_4_20_TO = 8'h8E;
  // ==========================================================
  // reset values and bus answers
  localparam logic [7:0]  RST_STATE = ST_INVALID;
  localparam logic [15:0] RST_CTL   = CW_STOP;
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  function automatic logic is_bus(input logic [7:0] fn);
    return (fn >= FN_BUS_0_20) && (fn <= FN_BUS_4_20_TO);
  endfunction

  function automatic logic has_preset(input logic [7:0] fn);
    return (fn == FN_BUS_0_20_TO) || (fn == FN_BUS_4_20_TO);
  endfunction

  function automatic logic is_4ma(input logic [7:0] fn);
    return (fn == FN_BUS_4_20) || (fn == FN_BUS_4_20_TO);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction
endpackage
`default_nettype wire

// file: net_node.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// network node: axi4-lite master writing the input variables
module net_node (
  // clock
  input  wire logic        aclk,
  // write side
  output logic             awvalid,
  input  wire logic        awready,
  output logic [7:0]       awaddr,
  output logic             wvalid,
  input  wire logic        wready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  input  wire logic        bvalid,
  output logic             bready,
  input  wire logic [1:0]  bresp,
  // read side
  output logic             arvalid,
  input  wire logic        arready,
  output logic [7:0]       araddr,
  input  wire logic        rvalid,
  output logic             rready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp
);
  // idle bus at time zero
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
  end
  // released lines carry inverted data so a stale value never passes
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, d, 4'hF};
    {awvalid, wvalid, bready} <= 3'b111;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) {awvalid, awaddr} <= {1'b0, ~a};
      if (wvalid && wready) {wvalid, wdata} <= {1'b0, ~d};
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask
  // one read, data taken at the rvalid edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    forever begin
      @(posedge aclk);
      if (arvalid && arready) {arvalid, araddr} <= {1'b0, ~a};
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: tb_drive_network_input_decoder.sv
`timescale 1ns/100ps
`default_nettype none
module tb_drive_network_input_decoder
  import drive_nv_pkg::*;
;
  // ==========
  // signals
  logic             aclk, aresetn, bus_timeout, reference_hz, reference_is_setpoint;
  logic             awvalid, awready, wvalid, wready, bvalid, bready;
  logic             arvalid, arready, rvalid, rready;
  logic [7:0]       awaddr, araddr;
  logic [31:0]      wdata, rdata, rv;
  logic [3:0]       wstrb, ao_enable, ao_span_4ma;
  logic [1:0]       bresp, rresp, resp;
  logic [15:0]      drive_ctl, drive_reference;
  logic [2:0][15:0] closed_loop_setpoint_inputs, network_feedback_inputs;
  logic [63:0]      discrete_output_word;
  logic [3:0][15:0] ao_level;
  int               errors, samples_checked;
  // rows: address, data, control word, reference, hz flag
  localparam logic [72:0] ROWS [20] = '{
    {8'h00, 32'h0100, 16'h047C, 16'h0000, 1'b0}, {8'h00, 32'h0000, 16'h043C, 16'h0000, 1'b0},
    {8'h00, 32'h0101, 16'h047C, 16'h0064, 1'b0}, {8'h00, 32'h01C8, 16'h047C, 16'h4E20, 1'b0},
    {8'h00, 32'h0102, 16'h047C, 16'h00C8, 1'b0}, {8'h00, 32'h01C9, 16'h047C, 16'h4E20, 1'b0},
    {8'h00, 32'h0103, 16'h047C, 16'h012C, 1'b0}, {8'h00, 32'h01FF, 16'h047C, 16'h4E20, 1'b0},
    {8'h00, 32'hFF00, 16'h047C, 16'h4E20, 1'b0}, {8'h08, 32'h0100, 16'h04BC, 16'h4E20, 1'b0},
    {8'h08, 32'hFF00, 16'h04BC, 16'h4E20, 1'b0}, {8'h08, 32'h0000, 16'h043C, 16'h4E20, 1'b0},
    {8'h04, 32'h1234, 16'h1234, 16'h4E20, 1'b0}, {8'h0C, 32'h0ABC, 16'h1234, 16'h0ABC, 1'b0},
    {8'h10, 32'h0123, 16'h1234, 16'h0ABC, 1'b0}, {8'h0C, 32'h0000, 16'h1234, 16'h0123, 1'b1},
    {8'h10, 32'h0000, 16'h1234, 16'h4E20, 1'b0}, {8'h0C, 32'hFFF6, 16'h1234, 16'hFFF6, 1'b0},
    {8'h10, 32'hFFFF, 16'h1234, 16'hFFF6, 1'b0}, {8'h0C, 32'h0000, 16'h1234, 16'hFFFF, 1'b1}};
  localparam logic [7:0] CODES [6] = '{8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h8F};

  drive_network_input_decoder u_drive_network_input_decoder (.*);
  net_node u_net_node (.*);

  // ==========
  // clock, watchdog, reporting
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  initial begin
    #100000;
    errors++;
    give_verdict();
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========
  // main sequence
  initial begin
    aresetn = 1'b0;
    bus_timeout = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // control word takes 2 edges, reference 3, after the write lands
    foreach (ROWS[i]) begin
      u_net_node.wr(ROWS[i][72:65], ROWS[i][64:33], resp);
      repeat (4) @(posedge aclk);
      chk(drive_ctl, ROWS[i][32:17]);
      chk(drive_reference, ROWS[i][16:1]);
      chk(reference_hz, ROWS[i][0]);
    end
    done("table");
    // unmapped place and readback
    u_net_node.wr(8'h80, 32'h1, resp);
    chk(resp, RESP_SLVERR);
    u_net_node.rd(8'h80, rv, resp);
    chk({resp, rv}, {RESP_SLVERR, 32'h0});
    u_net_node.rd(OFF_STATUS, rv, resp);
    chk(rv[15:0], 16'h1234);
    done("bus");
    // discrete outputs, reserved bits stay clear
    u_net_node.wr(OFF_DOUT_LO, 32'hFFFF_FFFF, resp);
    u_net_node.wr(OFF_DOUT_HI, 32'hFFFF_FFFF, resp);
    @(posedge aclk);
    chk(discrete_output_word, 64'h1FF);
    u_net_node.wr(OFF_DOUT_LO, 32'h0000_0155, resp);
    @(posedge aclk);
    chk(discrete_output_word, 64'h155);
    done("discrete");
    // setpoints and feedbacks at the signed extremes
    for (int i = 0; i < 3; i++) begin
      u_net_node.wr(OFF_SETPT[i], 32'h8000 + i, resp);
      u_net_node.wr(OFF_FBK[i], 32'h7FFF - i, resp);
    end
    @(posedge aclk);
    for (int i = 0; i < 3; i++) begin
      chk(closed_loop_setpoint_inputs[i], 16'h8000 + i);
      chk(network_feedback_inputs[i], 16'h7FFF - i);
    end
    done("closed loop");
    // analog outputs: a preset 0-20, b hold 4-20, both boards fitted
    u_net_node.wr(OFF_CONFIG, 32'h0007_8C8D, resp);
    u_net_node.wr(OFF_PRESET, 32'h0BB8_07D0, resp);
    for (int i = 0; i < 4; i++) u_net_node.wr(OFF_AO[i], 32'h0111 * (i + 1), resp);
    repeat (3) @(posedge aclk);
    chk(ao_level, {16'h0444, 16'h0333, 16'h0222, 16'h0111});
    chk({reference_is_setpoint, ao_enable, ao_span_4ma}, 9'h1F2);
    bus_timeout <= 1'b1;
    @(posedge aclk);
    bus_timeout <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(ao_level, {16'h0444, 16'h0333, 16'h0222, 16'h07D0});
    done("analog");
    // function codes 0x8A to 0x8F on output a, boards removed
    foreach (CODES[i]) begin
      u_net_node.wr(OFF_CONFIG, {24'h0, CODES[i]}, resp);
      repeat (3) @(posedge aclk);
      chk(ao_enable, {3'b000, CODES[i] inside {[8'h8B:8'h8E]}});
      chk(ao_span_4ma[0], CODES[i] == 8'h8C || CODES[i] == 8'h8E);
    end
    done("codes");
    // second reset in mid-run
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({drive_ctl, discrete_output_word[15:0], ao_enable}, {CW_STOP, 16'h0, 4'h0});
    done("reset");
    give_verdict();
  end
endmodule
`default_nettype wire
